// ### hw/drd_pkg.sv
package drd_pkg;
   // register byte addresses
   localparam logic [7:0] A_MODE = 8'h00;
   localparam logic [7:0] A_IENCLR = 8'h04;
   localparam logic [7:0] A_IENSET = 8'h08;
   localparam logic [7:0] A_FLAG = 8'h0c;
   localparam logic [7:0] A_CTRL0 = 8'h10;
   localparam logic [7:0] A_CTRL1 = 8'h14;
   localparam logic [7:0] A_VALUE0 = 8'h18;
   localparam logic [7:0] A_VALUE1 = 8'h1c;
   localparam logic [7:0] A_STAT = 8'h20;
   // field positions
   localparam int CUR_LSB = 0;
   localparam int STBY_BIT = 7;
   localparam int RFP_LSB = 8;
   localparam int DIFFERENTIAL_SELECT_BIT = 0;
   localparam int EMPTY_LSB = 2;
   localparam int UNDER_LSB = 0;
   localparam int PEND_LSB = 2;
   localparam int BUSY_LSB = 0;
   // values after reset
   localparam logic [3:0] IEN_RST = 4'h0;
   localparam logic [11:0] CTRL_RST = 12'h000;
   localparam logic [11:0] DATA_RST = 12'h000;
   // refresh field codes that leave refresh off
   localparam logic [3:0] RFP_OFF = 4'h0;
   localparam logic [3:0] RFP_RSVD = 4'h1;
   // conversion time and its cycle count at the bus clock
   localparam int CONV_NS = 1000;
   localparam int CLK_NS = 10;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic {
      DRD_IDLE = 1'b0,
      DRD_CONV = 1'b1
   } drd_ch_t;
endpackage

// ### hw/drd_refresh.sv
`timescale 1ns/1ps
module drd_refresh (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] period,
   input wire logic active,
   input wire logic tick,
   input wire logic restart,
   output logic due
);
   typedef struct packed {
      logic [3:0] cnt;
      logic due;
   } drd_rf_st_t;

   drd_rf_st_t s;
   drd_rf_st_t n;
   logic run;

   // off for code 0 and reserved code 1
   assign run = active && (period > drd_pkg::RFP_RSVD);

   always_comb begin
      n = s;
      n.due = 1'b0;
      if (restart || !run) begin
         n.cnt = 4'h0;
      end else if (tick) begin
         // period counted in slow oscillator ticks
         if (4'(s.cnt + 4'h1) == period) begin
            n.cnt = 4'h0;
            n.due = 1'b1;
         end else begin
            n.cnt = 4'(s.cnt + 4'h1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign due = s.due;

   a_due_on_tick: assert property (@(posedge ref_clk) disable iff (!nrst)
      s.due |-> $past(tick) && $past(run) && $past(s.cnt) == 4'($past(period) - 4'h1))
      else $error("refresh due without a completed period");
endmodule

// ### hw/drd_top.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module drd_top #(
   parameter int CONV_CYCLES = drd_pkg::CONV_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic slow_tick,
   input wire logic standby_sleep,
   input wire logic [1:0] sample_trig,
   output logic conv_start0,
   output logic conv_start1,
   output logic [11:0] conv_value0,
   output logic [11:0] conv_value1,
   output logic [1:0] current_sel0,
   output logic [1:0] current_sel1,
   output logic differential_select_mode,
   output logic irq
);
   // the busy counter is eight bits wide, so longer conversions cannot be timed
   if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_conv_range
      $error("conversion cycles out of range");
   end

   localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

   typedef struct packed {
      logic hready;
      logic resp;
      logic [31:0] rdata;
      logic wpend;
      logic [7:0] waddr;
      logic differential_select;
      logic [3:0] ien;
      logic [3:0] flag;
      logic irq;
      logic [1:0][11:0] ctrl;
      logic [1:0][11:0] data;
      drd_pkg::drd_ch_t [1:0] st;
      logic [1:0][7:0] cnt;
      logic [1:0] pend;
      logic [1:0] rdue;
      logic [1:0][11:0] val;
      logic [1:0] start;
      logic [1:0][1:0] cur;
   } drd_st_t;

   drd_st_t s;
   drd_st_t n;
   logic [1:0] due;
   logic [1:0] act;
   logic [1:0][11:0] ectl;
   logic rd_req;
   logic wr_req;
   logic [1:0] dwr;

   ////////////////////////////////////////////////////////////////////
   // channel configuration and refresh timers

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         // differential mode: channel-zero control serves both
         assign ectl[g] = s.differential_select ? s.ctrl[0] : s.ctrl[g];
         // refresh runs in standby only when allowed
         assign act[g] = !standby_sleep || ectl[g][drd_pkg::STBY_BIT];
         drd_refresh u_rf (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .period(ectl[g][drd_pkg::RFP_LSB +: 4]),
            .active(act[g]),
            .tick(slow_tick),
            .restart(s.start[g]),
            .due(due[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // bus decode

   assign rd_req = hsel && htrans[1] && hready && !hwrite;
   assign wr_req = hsel && htrans[1] && hready && hwrite;
   assign dwr[0] = s.wpend && s.waddr == drd_pkg::A_VALUE0;
   assign dwr[1] = s.wpend && s.waddr == drd_pkg::A_VALUE1;

   always_comb begin
      n = s;
      n.hready = 1'b1;
      // single whole-word transfers only, so the answer is always OKAY
      n.resp = 1'b0;
      n.wpend = wr_req;
      n.waddr = haddr[7:0];
      n.start = 2'b00;

      // read data is captured at the address phase
      n.rdata = 32'h0000_0000;
      if (rd_req) begin
         unique case (haddr[7:0])
            drd_pkg::A_MODE: n.rdata[drd_pkg::DIFFERENTIAL_SELECT_BIT] = s.differential_select;
            // both views show the one enable set
            drd_pkg::A_IENCLR: n.rdata[3:0] = s.ien;
            drd_pkg::A_IENSET: n.rdata[3:0] = s.ien;
            drd_pkg::A_FLAG: n.rdata[3:0] = s.flag;
            drd_pkg::A_CTRL0: n.rdata[11:0] = s.ctrl[0];
            drd_pkg::A_CTRL1: n.rdata[11:0] = s.ctrl[1];
            drd_pkg::A_VALUE0: n.rdata[11:0] = s.data[0];
            drd_pkg::A_VALUE1: n.rdata[11:0] = s.data[1];
            drd_pkg::A_STAT: begin
               n.rdata[drd_pkg::BUSY_LSB +: 2] = {s.st[1], s.st[0]};
               n.rdata[drd_pkg::PEND_LSB +: 2] = s.pend;
            end
            default: n.rdata = 32'h0000_0000;
         endcase
         // reading the flags clears them; events below still win
         if (haddr[7:0] == drd_pkg::A_FLAG) begin
            n.flag = 4'h0;
         end
      end

      // writes land at the end of the data phase
      if (s.wpend) begin
         unique case (s.waddr)
            drd_pkg::A_MODE: n.differential_select = hwdata[drd_pkg::DIFFERENTIAL_SELECT_BIT];
            // ones clear, zeros leave alone
            drd_pkg::A_IENCLR: n.ien = s.ien & ~hwdata[3:0];
            drd_pkg::A_IENSET: n.ien = s.ien | hwdata[3:0];
            drd_pkg::A_CTRL0: n.ctrl[0] = hwdata[11:0];
            drd_pkg::A_CTRL1: n.ctrl[1] = hwdata[11:0];
            drd_pkg::A_VALUE0: n.data[0] = hwdata[11:0];
            drd_pkg::A_VALUE1: n.data[1] = hwdata[11:0];
            default: n.ctrl = s.ctrl;
         endcase
      end

      ////////////////////////////////////////////////////////////////
      // conversion sequencing per channel

      for (int i = 0; i < 2; i++) begin
         n.cur[i] = ectl[i][drd_pkg::CUR_LSB +: 2];
         if (due[i]) begin
            n.rdue[i] = 1'b1;
         end
         unique case (s.st[i])
            drd_pkg::DRD_IDLE: begin
               if (s.pend[i]) begin
                  n.val[i] = s.data[i];
                  n.pend[i] = 1'b0;
                  n.start[i] = 1'b1;
                  n.flag[drd_pkg::EMPTY_LSB + i] = 1'b1;
               end else if (s.rdue[i] || sample_trig[i]) begin
                  // nothing new: convert the held value again
                  n.val[i] = s.data[i];
                  n.start[i] = 1'b1;
                  if (sample_trig[i]) begin
                     n.flag[drd_pkg::UNDER_LSB + i] = 1'b1;
                  end
               end
               if (n.start[i]) begin
                  n.st[i] = drd_pkg::DRD_CONV;
                  n.cnt[i] = CONV_LAST;
                  n.rdue[i] = due[i];
               end
            end
            drd_pkg::DRD_CONV: begin
               if (s.cnt[i] == 8'h00) begin
                  n.st[i] = drd_pkg::DRD_IDLE;
               end else begin
                  n.cnt[i] = 8'(s.cnt[i] - 8'h01);
               end
            end
         endcase
         // a write while busy waits for the idle slot
         if (dwr[i]) begin
            n.pend[i] = 1'b1;
         end
      end

      // differential: channel one tracks channel zero exactly
      if (s.differential_select) begin
         n.st[1] = n.st[0];
         n.cnt[1] = n.cnt[0];
         n.val[1] = n.val[0];
         n.start[1] = n.start[0];
         n.pend[1] = 1'b0;
         n.rdue[1] = 1'b0;
         n.flag[drd_pkg::EMPTY_LSB + 1] = s.flag[drd_pkg::EMPTY_LSB + 1] &&
            !(rd_req && haddr[7:0] == drd_pkg::A_FLAG);
         n.flag[drd_pkg::UNDER_LSB + 1] = s.flag[drd_pkg::UNDER_LSB + 1] &&
            !(rd_req && haddr[7:0] == drd_pkg::A_FLAG);
      end

      n.irq = |(n.flag & n.ien);
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.hready <= 1'b1;
         s.ien <= drd_pkg::IEN_RST;
         s.ctrl <= {drd_pkg::CTRL_RST, drd_pkg::CTRL_RST};
         s.data <= {drd_pkg::DATA_RST, drd_pkg::DATA_RST};
      end else begin
         s <= n;
      end
   end

   assign hreadyout = s.hready;
   assign hresp = s.resp;
   assign hrdata = s.rdata;
   assign conv_start0 = s.start[0];
   assign conv_start1 = s.start[1];
   assign conv_value0 = s.val[0];
   assign conv_value1 = s.val[1];
   assign current_sel0 = s.cur[0];
   assign current_sel1 = s.cur[1];
   assign differential_select_mode = s.differential_select;
   assign irq = s.irq;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence clr_write(int b);
      s.wpend && s.waddr == drd_pkg::A_IENCLR && hwdata[b];
   endsequence

   sequence ien_read;
      rd_req && (haddr[7:0] == drd_pkg::A_IENCLR ||
         haddr[7:0] == drd_pkg::A_IENSET);
   endsequence

   a_cur_select: assert property (
      ##1 current_sel1 == $past(s.differential_select ? s.ctrl[0][1:0] : s.ctrl[1][1:0]))
      else $error("buffer current not from active control");

   a_refresh_off: assert property (
      ectl[0][drd_pkg::RFP_LSB +: 4] <= drd_pkg::RFP_RSVD &&
      !s.differential_select [*2] |=> !due[0])
      else $error("refresh fired with refresh off");

   a_refresh_again: assert property (
      s.st[0] == drd_pkg::DRD_IDLE && s.rdue[0] && !s.pend[0]
      |=> conv_start0 && conv_value0 == $past(s.data[0]))
      else $error("refresh did not reconvert held data");

   a_standby_gate: assert property (
      standby_sleep && !ectl[0][drd_pkg::STBY_BIT] [*2] |=> !due[0])
      else $error("refresh ran in standby without permission");

   a_defer_write: assert property (
      s.st[0] == drd_pkg::DRD_CONV && s.cnt[0] != 8'h00 && dwr[0]
      |=> s.pend[0] && !conv_start0 ##1 !conv_start0)
      else $error("new data not deferred during conversion");

   a_differential_select_sync: assert property (
      s.differential_select && $past(s.differential_select) |-> conv_start0 == conv_start1 &&
      conv_value0 == conv_value1)
      else $error("differential channels out of step");

   a_differential_select_enter: assert property (
      s.wpend && s.waddr == drd_pkg::A_MODE && hwdata[drd_pkg::DIFFERENTIAL_SELECT_BIT]
      |=> differential_select_mode)
      else $error("differential bit write ignored");

   a_clr_buffer_one_empty_enable: assert property (clr_write(3) |=> !s.ien[3])
      else $error("enable clear left buffer-one-empty set");

   a_clr_others: assert property (
      clr_write(0) or clr_write(1) or clr_write(2) |=>
      (s.ien[2:0] & $past(hwdata[2:0])) == 3'h0)
      else $error("enable clear missed a bit");

   a_clr_zero: assert property (
      s.wpend && s.waddr == drd_pkg::A_IENCLR && hwdata[3:0] == 4'h0
      |=> s.ien == $past(s.ien))
      else $error("zero write to enable clear changed enables");

   a_ien_view: assert property (ien_read |=>
      hrdata == {28'h0, $past(s.ien)})
      else $error("enable read does not match shared enables");

   a_irq_level: assert property (
      ##1 irq == |($past(n.flag) & $past(n.ien)) && irq == |(s.flag & s.ien))
      else $error("interrupt level wrong");

   // held so the analog side sees one value per conversion
   a_value_hold: assert property (
      !conv_start0 |-> $stable(conv_value0))
      else $error("converted value changed without a start");

   a_start_single: assert property (
      conv_start0 |=> !conv_start0)
      else $error("conversion restarted while busy");

   a_differential_select_config: assert property (
      s.differential_select |=> current_sel1 == current_sel0)
      else $error("channel one current not from channel-zero control");

   // checked on the first edge after release
   a_ien_reset: assert property (
      $rose(nrst) |-> s.ien == drd_pkg::IEN_RST)
      else $error("enables not cleared by reset");

   a_set_view: assert property (
      s.wpend && s.waddr == drd_pkg::A_IENSET |=>
      (s.ien & $past(hwdata[3:0])) == $past(hwdata[3:0]))
      else $error("enable set write not visible");

   a_flag_sticky: assert property (
      s.flag[drd_pkg::EMPTY_LSB] && !(rd_req && haddr[7:0] == drd_pkg::A_FLAG)
      |=> s.flag[drd_pkg::EMPTY_LSB])
      else $error("buffer-zero-empty flag dropped without a read");
endmodule

// ### tb/test_dac_refresh_differential_control.sv
`timescale 1ns/1ps
module test_dac_refresh_differential_control;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   logic hreadyout, hresp, irq, differential_select_mode, conv_start0, conv_start1;
   logic [31:0] hrdata, r;
   logic slow_tick = 1'b0;
   logic standby_sleep = 1'b0;
   logic [1:0] sample_trig = 2'h0;
   logic [11:0] conv_value0, conv_value1, v0, v1;
   logic [1:0] current_sel0, current_sel1;
   int miscompares = 0;
   int checks_done = 0;
   int n0 = 0, n1 = 0, cyc = 0, last0 = 0, last1 = 0, gap0 = 0;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   drd_top #(.CONV_CYCLES(8)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .slow_tick(slow_tick), .standby_sleep(standby_sleep), .sample_trig(sample_trig),
      .conv_start0(conv_start0), .conv_start1(conv_start1), .conv_value0(conv_value0),
      .conv_value1(conv_value1), .current_sel0(current_sel0), .current_sel1(current_sel1),
      .differential_select_mode(differential_select_mode), .irq(irq));
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // non-blocking so scenario code reads a stable count after any edge
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (conv_start0 === 1'b1) begin
         n0 <= n0 + 1;
         v0 <= conv_value0;
         last0 <= cyc;
         gap0 <= cyc - last0;
      end
      if (conv_start1 === 1'b1) begin
         n1 <= n1 + 1;
         v1 <= conv_value1;
         last1 <= cyc;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic edge_rdy();
      int i;
      i = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1 && i < 50) begin
         @(posedge ref_clk);
         i++;
      end
      if (i == 50) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      edge_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic wait_start(input int n);
      int i;
      for (i = 0; i < 60 && n0 == n; i++) @(posedge ref_clk);
      if (n0 == n) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic tick(input int k);
      repeat (k) begin
         slow_tick <= 1'b1;
         @(posedge ref_clk);
         slow_tick <= 1'b0;
         repeat (12) @(posedge ref_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic reg_access();
      bus(drd_pkg::A_IENCLR, 1'b0, 32'h0);
      chk(r, 32'h0);
      bus(drd_pkg::A_IENSET, 1'b1, 32'hf);
      bus(drd_pkg::A_IENCLR, 1'b0, 32'h0);
      chk(r, 32'hf);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'h8);
      bus(drd_pkg::A_IENSET, 1'b0, 32'h0);
      chk(r, 32'h7);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'h0);
      bus(drd_pkg::A_IENCLR, 1'b0, 32'h0);
      chk(r, 32'h7);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'h5);
      bus(drd_pkg::A_IENCLR, 1'b0, 32'h0);
      chk(r, 32'h2);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'h2);
      bus(8'hfc, 1'b1, 32'hffff_ffff);
      bus(8'hfc, 1'b0, 32'h0);
      chk(r, 32'h0);
   endtask
   task automatic irq_events();
      bus(drd_pkg::A_IENSET, 1'b1, 32'h4);
      bus(drd_pkg::A_VALUE0, 1'b1, 32'h123);
      repeat (6) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      bus(drd_pkg::A_FLAG, 1'b0, 32'h0);
      chk({31'h0, r[2]}, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'h4);
      bus(drd_pkg::A_VALUE0, 1'b1, 32'h124);
      repeat (14) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      bus(drd_pkg::A_IENSET, 1'b1, 32'h1);
      bus(drd_pkg::A_FLAG, 1'b0, 32'h0);
      sample_trig <= 2'h1;
      @(posedge ref_clk);
      sample_trig <= 2'h0;
      repeat (4) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h1);
      bus(drd_pkg::A_FLAG, 1'b0, 32'h0);
      chk({31'h0, r[0]}, 32'h1);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'hf);
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic chan_one();
      bus(drd_pkg::A_IENSET, 1'b1, 32'ha);
      bus(drd_pkg::A_VALUE1, 1'b1, 32'h3c5);
      repeat (14) @(posedge ref_clk);
      chk({20'h0, v1}, 32'h3c5);
      chk({31'h0, irq}, 32'h1);
      sample_trig <= 2'h2;
      @(posedge ref_clk);
      sample_trig <= 2'h0;
      repeat (4) @(posedge ref_clk);
      bus(drd_pkg::A_FLAG, 1'b0, 32'h0);
      chk(r, 32'ha);
      bus(drd_pkg::A_IENCLR, 1'b1, 32'hf);
      repeat (12) @(posedge ref_clk);
   endtask
   // a start restarts the period, so k-1 ticks pass quietly and tick k converts
   task automatic refresh_run(input logic [31:0] ctrl, input logic [11:0] d, input int k,
      input int inc);
      int n;
      bus(drd_pkg::A_CTRL0, 1'b1, ctrl);
      bus(drd_pkg::A_VALUE0, 1'b1, {20'h0, d});
      repeat (14) @(posedge ref_clk);
      n = n0;
      tick(k - 1);
      chk(n0, n);
      tick(1);
      chk(n0, n + inc);
      if (inc > 0) begin
         chk({20'h0, v0}, {20'h0, d});
      end
   endtask
   task automatic defer_new();
      int n;
      bus(drd_pkg::A_CTRL0, 1'b1, 32'h200);
      bus(drd_pkg::A_VALUE0, 1'b1, 32'h111);
      repeat (14) @(posedge ref_clk);
      tick(1);
      n = n0;
      slow_tick <= 1'b1;
      @(posedge ref_clk);
      slow_tick <= 1'b0;
      wait_start(n);
      bus(drd_pkg::A_VALUE0, 1'b1, 32'h222);
      wait_start(n + 1);
      chk({20'h0, v0}, 32'h222);
      chk({31'h0, gap0 >= 9}, 32'h1);
   endtask
   task automatic differential_select_run();
      int n;
      bus(drd_pkg::A_CTRL0, 1'b1, 32'h002);
      bus(drd_pkg::A_CTRL1, 1'b1, 32'h001);
      repeat (2) @(posedge ref_clk);
      chk({30'h0, current_sel0}, 32'h2);
      chk({30'h0, current_sel1}, 32'h1);
      bus(drd_pkg::A_MODE, 1'b1, 32'h1);
      bus(drd_pkg::A_CTRL0, 1'b1, 32'h003);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, differential_select_mode}, 32'h1);
      chk({30'h0, current_sel1}, 32'h3);
      n = n1;
      bus(drd_pkg::A_VALUE0, 1'b1, 32'h801);
      repeat (14) @(posedge ref_clk);
      chk(n1, n + 1);
      chk({20'h0, v1}, 32'h801);
      chk({20'h0, v0}, 32'h801);
      chk(last1, last0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      reg_access();
      irq_events();
      chan_one();
      // code 0 and standby without permission run with refresh off; the reserved code is never written
      refresh_run(32'h300, 12'h321, 3, 1);
      refresh_run(32'h200, 12'h0ab, 2, 1);
      refresh_run(32'h400, 12'h0cd, 4, 1);
      refresh_run(32'h000, 12'h0ef, 4, 0);
      standby_sleep <= 1'b1;
      refresh_run(32'h380, 12'h456, 3, 1);
      refresh_run(32'h300, 12'h457, 4, 0);
      standby_sleep <= 1'b0;
      defer_new();
      differential_select_run();
      complete_run();
   end
endmodule
